// ===== hdl/acq_pkg.sv
package acq_pkg;

  // Register word addresses on the plain register port.
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_MODE   = 4'h1;
  localparam logic [3:0] ADDR_FRUN   = 4'h2;
  localparam logic [3:0] ADDR_FGRP   = 4'h3;
  localparam logic [3:0] ADDR_IPACE  = 4'h4;
  localparam logic [3:0] ADDR_RPACE  = 4'h5;
  localparam logic [3:0] ADDR_WIDTH  = 4'h6;
  localparam logic [3:0] ADDR_HEIGHT = 4'h7;
  localparam logic [3:0] ADDR_EXPO   = 4'h8;
  localparam logic [3:0] ADDR_PICK   = 4'h9;
  localparam logic [3:0] ADDR_VALUE  = 4'hA;
  localparam logic [3:0] ADDR_EVENT  = 4'hB;
  localparam logic [3:0] ADDR_MASK   = 4'hC;

  // Command bits of a write to the control register.
  localparam int CMD_PREPARE = 0;
  localparam int CMD_BEGIN   = 1;
  localparam int CMD_END     = 2;
  localparam int CMD_CANCEL  = 3;

  // Fields of the mode register.
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_TRIG    = 2;
  localparam int MODE_GBEGIN  = 3;
  localparam int MODE_GEND    = 4;
  localparam int MODE_GLEVEL  = 5;
  localparam int MODE_LSCAN   = 6;

  // Event bits of the sticky status and mask registers.
  localparam int EV_FRAME = 0;
  localparam int EV_GROUP = 1;
  localparam int EV_RUN   = 2;
  localparam int EV_ERROR = 3;

  // Positions of the synchronised trigger pins.
  localparam int PIN_GBEGIN = 0;
  localparam int PIN_GEND   = 1;
  localparam int PIN_GLEVEL = 2;
  localparam int PIN_IMAGE  = 3;
  localparam int PIN_ROW    = 4;

  // Reset values of the software registers.
  localparam logic [6:0]  RST_MODE   = 7'h02;
  localparam logic [15:0] RST_FRUN   = 16'h0001;
  localparam logic [15:0] RST_FGRP   = 16'h0001;
  localparam logic [31:0] RST_IPACE  = 32'h00000400;
  localparam logic [15:0] RST_RPACE  = 16'h0010;
  localparam logic [15:0] RST_WIDTH  = 16'h0008;
  localparam logic [15:0] RST_HEIGHT = 16'h0008;
  localparam logic [15:0] RST_EXPO   = 16'h0004;

  typedef enum logic [1:0] {
    MODE_ONE_SHOT    = 2'b00,
    MODE_COUNTED_RUN = 2'b01,
    MODE_CONTINUOUS  = 2'b10
  } acq_mode_type;

  typedef enum logic [2:0] {
    ST_IDLE       = 3'b000,
    ST_GROUP_WAIT = 3'b001,
    ST_FRAME_WAIT = 3'b010,
    ST_EXPOSE     = 3'b011,
    ST_LINE_WAIT  = 3'b100,
    ST_READ       = 3'b101
  } acq_fsm_type;

endpackage : acq_pkg

// ===== hdl/acq_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module acq_sequencer
  import acq_pkg::*;
(
  input  wire logic        MCLK,               // Clock, 20 MHz.
  input  wire logic        SYS_RST,            // Synchronous reset, active high.
  input  wire logic [3:0]  ADDR,               // Register word address.
  input  wire logic [31:0] WDATA,              // Register write data.
  input  wire logic        WR,                 // Write strobe.
  input  wire logic        RD,                 // Read strobe.
  output logic      [31:0] RDATA,              // Read data, cycle after RD.
  input  wire logic        GROUP_BEGIN_TRIG,   // Group begin trigger pin.
  input  wire logic        GROUP_END_TRIG,     // Group end trigger pin.
  input  wire logic        GROUP_LEVEL_TRIG,   // Level group trigger pin.
  input  wire logic        IMAGE_TRIG,         // Frame trigger pin.
  input  wire logic        ROW_TRIG,           // Line trigger pin.
  input  wire logic        XFER_BUSY,          // Downstream frame transfer busy.
  output logic             RUN_TRIG_WAIT,      // Waiting for a group trigger.
  output logic             RUN_BUSY,           // Acquisition active.
  output logic             RUN_XFER,           // Acquisition transfer interval.
  output logic             GROUP_XFER,         // Group transfer interval.
  output logic             IMAGE_TRIG_WAIT,    // Waiting to start a frame.
  output logic             IMAGE_BUSY,         // Frame active.
  output logic             INTEGRATING,        // Exposure active.
  output logic             READOUT,            // Sensor line readout active.
  output logic             IRQ                 // Level interrupt.
);

  typedef struct packed {
    logic [4:0]   sync1;
    logic [4:0]   sync2;
    logic [4:0]   prev;
    logic [6:0]   mode;
    logic [15:0]  frun;
    logic [15:0]  fgrp;
    logic [31:0]  ipace;
    logic [15:0]  rpace;
    logic [15:0]  width;
    logic [15:0]  height;
    logic [15:0]  expo;
    logic [2:0]   pick;
    logic [3:0]   mask;
    logic [3:0]   events;
    logic [6:0]   f_mode;
    logic [15:0]  f_frun;
    logic [15:0]  f_fgrp;
    logic [31:0]  f_ipace;
    logic [15:0]  f_rpace;
    logic [15:0]  f_width;
    logic [15:0]  f_height;
    logic [15:0]  f_expo;
    logic         armed;
    acq_fsm_type  fsm;
    logic         stop_pend;
    logic         in_group;
    logic         gend_pend;
    logic [31:0]  frame_tmr;
    logic [15:0]  line_tmr;
    logic [15:0]  cnt;
    logic [15:0]  line;
    logic [15:0]  frames;
    logic [15:0]  gframes;
    logic         run_xfer;
    logic         group_xfer;
    logic [31:0]  rdata;
  } acq_state_type;

  acq_state_type st;
  acq_state_type next_st;

  logic [4:0]  pins;
  logic [4:0]  edge_seen;
  logic        cfg_ok;
  logic        trig_on;
  logic        lscan;
  logic        g_begin;
  logic        g_end;
  logic        g_level;
  logic        groups_on;
  logic        level_hi;
  logic        line_go;
  logic        run_done;
  logic        group_close;
  logic [3:0]  ev_set;
  logic [7:0]  status_vec;
  acq_mode_type f_sel;

  assign pins = {ROW_TRIG, IMAGE_TRIG, GROUP_LEVEL_TRIG, GROUP_END_TRIG, GROUP_BEGIN_TRIG};

  // Rising edges are taken from the second synchroniser stage only.
  assign edge_seen = st.sync2 & ~st.prev;

  assign f_sel     = acq_mode_type'(st.f_mode[MODE_SEL_LSB +: 2]);
  assign trig_on   = st.f_mode[MODE_TRIG];
  assign lscan     = st.f_mode[MODE_LSCAN];
  assign g_begin   = st.f_mode[MODE_GBEGIN];
  assign g_end     = st.f_mode[MODE_GEND];
  assign g_level   = st.f_mode[MODE_GLEVEL];
  assign groups_on = g_begin | g_level;
  assign level_hi  = st.sync2[PIN_GLEVEL];

  // Settings check performed when capture settings are frozen.
  always_comb begin
    cfg_ok = (st.width != 16'h0000) && (st.height != 16'h0000);
    if (st.mode[MODE_SEL_LSB +: 2] == 2'b11) begin
      cfg_ok = 1'b0;
    end
    if (st.mode[MODE_SEL_LSB +: 2] == MODE_COUNTED_RUN && st.frun == 16'h0000) begin
      cfg_ok = 1'b0;
    end
    if (st.mode[MODE_GBEGIN] && !st.mode[MODE_GEND] && st.fgrp == 16'h0000) begin
      cfg_ok = 1'b0;
    end
  end

  // Line start gate: row trigger when triggering is on, row pace otherwise.
  assign line_go = trig_on ? edge_seen[PIN_ROW] : (st.line_tmr <= 16'h0001);

  // Decisions taken when the last line of a frame has been read out.
  assign run_done = st.stop_pend
                  || (f_sel == MODE_ONE_SHOT)
                  || (f_sel == MODE_COUNTED_RUN && st.frames + 16'h0001 >= st.f_frun);

  always_comb begin
    group_close = 1'b0;
    if (g_level) begin
      group_close = !level_hi;
    end else if (g_begin && g_end) begin
      group_close = st.gend_pend;
    end else if (g_begin) begin
      group_close = (st.gframes + 16'h0001 >= st.f_fgrp);
    end
  end

  assign status_vec = {1'b0, st.group_xfer, INTEGRATING, IMAGE_BUSY, IMAGE_TRIG_WAIT,
                       st.run_xfer, RUN_BUSY, RUN_TRIG_WAIT};

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_st       = st;
    ev_set        = 4'h0;
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;
    next_st.rdata = 32'h00000000;

    if (st.frame_tmr != 32'h00000000) begin
      next_st.frame_tmr = st.frame_tmr - 32'h00000001;
    end
    if (st.line_tmr != 16'h0000) begin
      next_st.line_tmr = st.line_tmr - 16'h0001;
    end

    // Software register writes; commands are one-cycle actions.
    if (WR) begin
      unique case (ADDR)
        ADDR_MODE:   next_st.mode   = WDATA[6:0];
        ADDR_FRUN:   next_st.frun   = WDATA[15:0];
        ADDR_FGRP:   next_st.fgrp   = WDATA[15:0];
        ADDR_IPACE:  next_st.ipace  = WDATA;
        ADDR_RPACE:  next_st.rpace  = WDATA[15:0];
        ADDR_WIDTH:  next_st.width  = WDATA[15:0];
        ADDR_HEIGHT: next_st.height = WDATA[15:0];
        ADDR_EXPO:   next_st.expo   = WDATA[15:0];
        ADDR_PICK:   next_st.pick   = WDATA[2:0];
        ADDR_MASK:   next_st.mask   = WDATA[3:0];
        default: ;
      endcase
    end

    // Sequencer.
    unique case (st.fsm)
      ST_IDLE: begin
        if (WR && ADDR == ADDR_CTRL && (WDATA[CMD_PREPARE] || WDATA[CMD_BEGIN])) begin
          if (st.armed && WDATA[CMD_BEGIN]) begin
            next_st.armed = 1'b1;
          end else if (cfg_ok) begin
            next_st.armed    = 1'b1;
            next_st.f_mode   = st.mode;
            next_st.f_frun   = st.frun;
            next_st.f_fgrp   = st.fgrp;
            next_st.f_ipace  = st.ipace;
            next_st.f_rpace  = st.rpace;
            next_st.f_width  = st.width;
            next_st.f_height = st.height;
            next_st.f_expo   = st.expo;
          end else begin
            ev_set[EV_ERROR] = 1'b1;
          end
          if (WDATA[CMD_BEGIN] && (st.armed || cfg_ok)) begin
            next_st.frames    = 16'h0000;
            next_st.stop_pend = 1'b0;
            next_st.in_group  = 1'b0;
            next_st.frame_tmr = 32'h00000000;
            if (st.armed ? groups_on
                         : (st.mode[MODE_GBEGIN] || st.mode[MODE_GLEVEL])) begin
              next_st.fsm = ST_GROUP_WAIT;
            end else begin
              next_st.fsm = ST_FRAME_WAIT;
            end
          end
        end
      end
      ST_GROUP_WAIT: begin
        if (st.stop_pend) begin
          next_st.fsm = ST_IDLE;
        end else if (g_level ? level_hi : edge_seen[PIN_GBEGIN]) begin
          next_st.in_group  = 1'b1;
          next_st.gframes   = 16'h0000;
          next_st.gend_pend = 1'b0;
          next_st.fsm       = ST_FRAME_WAIT;
        end
      end
      ST_FRAME_WAIT: begin
        if (st.stop_pend) begin
          next_st.fsm = ST_IDLE;
        end else if (g_level && !level_hi) begin
          next_st.in_group = 1'b0;
          next_st.fsm      = ST_GROUP_WAIT;
        end else if (trig_on ? edge_seen[PIN_IMAGE]
                             : (st.frame_tmr <= 32'h00000001)) begin
          next_st.frame_tmr = st.f_ipace;
          next_st.line      = 16'h0000;
          next_st.cnt       = st.f_expo;
          next_st.line_tmr  = 16'h0000;
          next_st.fsm       = (lscan || st.f_expo == 16'h0000) ? ST_LINE_WAIT : ST_EXPOSE;
        end
      end
      ST_EXPOSE: begin
        if (st.cnt <= 16'h0001) begin
          next_st.cnt = st.f_width;
          next_st.fsm = lscan ? ST_READ : ST_LINE_WAIT;
        end else begin
          next_st.cnt = st.cnt - 16'h0001;
        end
      end
      ST_LINE_WAIT: begin
        if (line_go) begin
          next_st.line_tmr = st.f_rpace;
          if (lscan && st.f_expo != 16'h0000) begin
            next_st.cnt = st.f_expo;
            next_st.fsm = ST_EXPOSE;
          end else begin
            next_st.cnt = st.f_width;
            next_st.fsm = ST_READ;
          end
        end
      end
      ST_READ: begin
        if (st.cnt > 16'h0001) begin
          next_st.cnt = st.cnt - 16'h0001;
        end else if (st.line + 16'h0001 < st.f_height) begin
          next_st.line = st.line + 16'h0001;
          next_st.fsm  = ST_LINE_WAIT;
        end else begin
          // Frame ends with readout; transfer may still be running.
          ev_set[EV_FRAME] = 1'b1;
          next_st.frames   = st.frames + 16'h0001;
          next_st.gframes  = st.gframes + 16'h0001;
          if (run_done) begin
            next_st.fsm      = ST_IDLE;
            ev_set[EV_RUN]   = 1'b1;
            ev_set[EV_GROUP] = st.in_group;
          end else if (groups_on && group_close) begin
            next_st.in_group = 1'b0;
            ev_set[EV_GROUP] = 1'b1;
            next_st.fsm      = ST_GROUP_WAIT;
          end else begin
            next_st.fsm = ST_FRAME_WAIT;
          end
        end
      end
      default: next_st.fsm = ST_IDLE;
    endcase

    // A group end trigger is remembered until the frame in progress finishes.
    if (st.in_group && edge_seen[PIN_GEND] && next_st.in_group) begin
      next_st.gend_pend = 1'b1;
    end

    if (WR && ADDR == ADDR_CTRL && WDATA[CMD_END] && st.fsm != ST_IDLE) begin
      next_st.stop_pend = 1'b1;
    end

    // Cancel returns the sequencer to idle from any state, even a frame mid-readout.
    if (WR && ADDR == ADDR_CTRL && WDATA[CMD_CANCEL]) begin
      next_st.fsm      = ST_IDLE;
      next_st.in_group = 1'b0;
      ev_set[EV_RUN]   = (st.fsm != ST_IDLE);
    end

    if (next_st.fsm == ST_IDLE) begin
      next_st.stop_pend = 1'b0;
      next_st.in_group  = 1'b0;
      if (st.fsm != ST_IDLE) begin
        next_st.armed = 1'b0;
      end
    end

    // Transfer intervals follow the downstream busy level, not the frame.
    if (RUN_BUSY && XFER_BUSY) begin
      next_st.run_xfer = 1'b1;
    end else if (!RUN_BUSY && !XFER_BUSY) begin
      next_st.run_xfer = 1'b0;
    end
    if (st.in_group && XFER_BUSY) begin
      next_st.group_xfer = 1'b1;
    end else if (!st.in_group && !XFER_BUSY) begin
      next_st.group_xfer = 1'b0;
    end

    // Register reads; the event register clears on read, but a new event wins.
    if (RD) begin
      unique case (ADDR)
        ADDR_CTRL:   next_st.rdata = {27'h0000000, st.stop_pend, st.armed, st.fsm};
        ADDR_MODE:   next_st.rdata = {25'h0000000, st.mode};
        ADDR_FRUN:   next_st.rdata = {16'h0000, st.frun};
        ADDR_FGRP:   next_st.rdata = {16'h0000, st.fgrp};
        ADDR_IPACE:  next_st.rdata = st.ipace;
        ADDR_RPACE:  next_st.rdata = {16'h0000, st.rpace};
        ADDR_WIDTH:  next_st.rdata = {16'h0000, st.width};
        ADDR_HEIGHT: next_st.rdata = {16'h0000, st.height};
        ADDR_EXPO:   next_st.rdata = {16'h0000, st.expo};
        ADDR_PICK:   next_st.rdata = {29'h00000000, st.pick};
        ADDR_VALUE:  next_st.rdata = {31'h00000000, status_vec[st.pick]};
        ADDR_EVENT:  next_st.rdata = {28'h0000000, st.events};
        ADDR_MASK:   next_st.rdata = {28'h0000000, st.mask};
        default:     next_st.rdata = 32'h00000000;
      endcase
    end
    if (RD && ADDR == ADDR_EVENT) begin
      next_st.events = ev_set;
    end else begin
      next_st.events = st.events | ev_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      st          <= '0;
      st.mode     <= RST_MODE;
      st.frun     <= RST_FRUN;
      st.fgrp     <= RST_FGRP;
      st.ipace    <= RST_IPACE;
      st.rpace    <= RST_RPACE;
      st.width    <= RST_WIDTH;
      st.height   <= RST_HEIGHT;
      st.expo     <= RST_EXPO;
      st.f_mode   <= RST_MODE;
      st.f_frun   <= RST_FRUN;
      st.f_fgrp   <= RST_FGRP;
      st.f_ipace  <= RST_IPACE;
      st.f_rpace  <= RST_RPACE;
      st.f_width  <= RST_WIDTH;
      st.f_height <= RST_HEIGHT;
      st.f_expo   <= RST_EXPO;
      st.fsm      <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  assign RDATA           = st.rdata;
  assign RUN_BUSY        = (st.fsm != ST_IDLE);
  assign RUN_TRIG_WAIT   = (st.fsm == ST_GROUP_WAIT);
  assign RUN_XFER        = st.run_xfer;
  assign GROUP_XFER      = st.group_xfer;
  assign IMAGE_TRIG_WAIT = (st.fsm == ST_FRAME_WAIT);
  assign IMAGE_BUSY      = (st.fsm == ST_EXPOSE) || (st.fsm == ST_LINE_WAIT)
                        || (st.fsm == ST_READ);
  assign INTEGRATING     = (st.fsm == ST_EXPOSE);
  assign READOUT         = (st.fsm == ST_READ);
  assign IRQ             = |(st.events & st.mask);

endmodule : acq_sequencer
`default_nettype wire

// ===== bench/acq_seq_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module acq_seq_checker
  import acq_pkg::*;
(
  input wire logic        MCLK,            // Clock.
  input wire logic        SYS_RST,         // Reset.
  input wire logic [3:0]  ADDR,            // Address.
  input wire logic [31:0] WDATA,           // Write data.
  input wire logic        WR,              // Write strobe.
  input wire logic        RD,              // Read strobe.
  input wire logic [31:0] RDATA,           // Read data.
  input wire logic        XFER_BUSY,       // Transfer busy.
  input wire logic        RUN_TRIG_WAIT,   // Group wait.
  input wire logic        RUN_BUSY,        // Run active.
  input wire logic        RUN_XFER,        // Run transfer.
  input wire logic        IMAGE_TRIG_WAIT, // Frame wait.
  input wire logic        IMAGE_BUSY,      // Frame active.
  input wire logic        INTEGRATING,     // Exposure.
  input wire logic        READOUT          // Readout.
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  logic cancel_wr;
  assign cancel_wr = WR && ADDR == ADDR_CTRL && WDATA[CMD_CANCEL];
  ////////////////////////////////////////
  a_group_wait_run: assert property (RUN_TRIG_WAIT |-> RUN_BUSY)
    else $error("group wait outside a run");
  a_frame_in_run: assert property (IMAGE_BUSY |-> RUN_BUSY && !IMAGE_TRIG_WAIT)
    else $error("frame active outside a run");
  a_expose_in_frame: assert property (INTEGRATING |-> IMAGE_BUSY && !READOUT)
    else $error("exposure outside a frame");
  a_readout_in_frame: assert property (READOUT |-> IMAGE_BUSY)
    else $error("readout outside a frame");
  a_cancel_idle: assert property (cancel_wr |=> !RUN_BUSY && !IMAGE_BUSY)
    else $error("cancel did not end capture");
  a_rdata_quiet: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data outside read cycle");
  a_xfer_follow: assert property (RUN_BUSY && XFER_BUSY |=> RUN_XFER)
    else $error("run transfer missed");
  a_xfer_drop: assert property (!RUN_BUSY && !XFER_BUSY |=> !RUN_XFER)
    else $error("run transfer stuck");
  cover property ($fell(RUN_BUSY));
  cover property ($rose(INTEGRATING));
  cover property ($rose(RUN_XFER));
endmodule : acq_seq_checker
bind acq_sequencer acq_seq_checker acq_seq_checker_inst (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .XFER_BUSY(XFER_BUSY), .RUN_TRIG_WAIT(RUN_TRIG_WAIT),
  .RUN_BUSY(RUN_BUSY), .RUN_XFER(RUN_XFER), .IMAGE_TRIG_WAIT(IMAGE_TRIG_WAIT),
  .IMAGE_BUSY(IMAGE_BUSY), .INTEGRATING(INTEGRATING), .READOUT(READOUT));
`default_nettype wire

// ===== bench/acq_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module acq_far_model (
  input  wire logic       MCLK,     // Clock.
  input  wire logic       READOUT,  // Readout active.
  input  wire logic [4:0] FIRE,     // Trigger requests.
  output logic      [4:0] TRIG,     // Trigger pins.
  output logic            XFER_BUSY // Transfer busy.
);
  logic [4:0] s0 = 5'h0;
  logic [4:0] s1 = 5'h0;
  logic [4:0] s2 = 5'h0;
  logic [3:0] hold = 4'h0;
  // Pulses stay three cycles so the pin synchroniser sees them.
  always @(posedge MCLK) begin
    s0 <= FIRE;
    s1 <= s0;
    s2 <= s1;
    hold <= READOUT ? 4'hA : (hold != 4'h0 ? hold - 4'h1 : 4'h0);
  end
  assign TRIG = s0 | s1 | s2;
  // Transfer starts in readout and runs on past it.
  assign XFER_BUSY = READOUT || hold != 4'h0;
endmodule : acq_far_model
`default_nettype wire

// ===== bench/tb_acq_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_acq_sequencer;
  import acq_pkg::*;
  typedef struct { logic [3:0] a; logic [31:0] e; } acq_row_type;
  localparam int W_TW = 1, W_RB = 2, W_IW = 3, W_IB = 4, W_IN = 5, W_RO = 6;
  logic        MCLK, SYS_RST, WR, RD, XFER_BUSY, RUN_TRIG_WAIT, RUN_BUSY, RUN_XFER;
  logic        GROUP_XFER, IMAGE_TRIG_WAIT, IMAGE_BUSY, INTEGRATING, READOUT, IRQ;
  logic [3:0]  ADDR;
  logic [31:0] WDATA, RDATA, v;
  logic [4:0]  FIRE, TRIG;
  logic [6:0]  sv;
  logic        p_img = 1'b0;
  logic        p_ro = 1'b0;
  int          failures = 0, checks = 0, frames = 0, rcount = 0, cyc = 0, icount = 0;
  int          img_at = 0, ro_at = 0, img_gap = 0, ro_gap = 0, n;
  acq_row_type rows [14] = '{'{ADDR_CTRL, 32'h0}, '{ADDR_MODE, 32'h2}, '{ADDR_FRUN, 32'h1},
    '{ADDR_FGRP, 32'h1}, '{ADDR_IPACE, 32'h400}, '{ADDR_RPACE, 32'h10}, '{ADDR_WIDTH, 32'h8},
    '{ADDR_HEIGHT, 32'h8}, '{ADDR_EXPO, 32'h4}, '{ADDR_PICK, 32'h0}, '{ADDR_VALUE, 32'h0},
    '{ADDR_EVENT, 32'h0}, '{ADDR_MASK, 32'h0}, '{4'hF, 32'h0}};
  assign sv = {READOUT, INTEGRATING, IMAGE_BUSY, IMAGE_TRIG_WAIT, RUN_BUSY, RUN_TRIG_WAIT, IRQ};
  acq_sequencer acq_sequencer_inst (.*, .GROUP_BEGIN_TRIG(TRIG[PIN_GBEGIN]),
    .GROUP_END_TRIG(TRIG[PIN_GEND]), .GROUP_LEVEL_TRIG(TRIG[PIN_GLEVEL]),
    .IMAGE_TRIG(TRIG[PIN_IMAGE]), .ROW_TRIG(TRIG[PIN_ROW]));
  acq_far_model acq_far_model_inst (.*);
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    p_img <= IMAGE_BUSY;
    p_ro <= READOUT;
    if (READOUT) rcount <= rcount + 1;
    if (INTEGRATING) icount <= icount + 1;
    if (IMAGE_BUSY && !p_img) begin
      frames <= frames + 1;
      img_gap <= cyc - img_at;
      img_at <= cyc;
    end
    if (READOUT && !p_ro) begin
      ro_gap <= cyc - ro_at;
      ro_at <= cyc;
    end
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    @(negedge MCLK);
    d = RDATA;
  endtask : rd
  task automatic cmd(input int b);
    wr(ADDR_CTRL, 32'h1 << b);
  endtask : cmd
  task automatic await(input int i, input logic lvl);
    for (n = 0; n < 4000 && sv[i] !== lvl; n++) @(negedge MCLK);
    if (sv[i] !== lvl) failures++;
  endtask : await
  task automatic fire(input int p);
    @(posedge MCLK);
    FIRE[p] <= 1'b1;
    @(posedge MCLK);
    FIRE[p] <= 1'b0;
  endtask : fire
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////
  initial begin
    #(30000 * 50);
    failures++;
    give_verdict();
  end
  initial begin
    SYS_RST = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 4'h0;
    WDATA = 32'h0;
    FIRE = 5'h0;
    repeat (20) @(posedge MCLK);
    SYS_RST <= 1'b0;
    wr(ADDR_VALUE, 32'hFFFFFFFF);
    wr(4'hF, 32'hFFFFFFFF);
    foreach (rows[i]) begin
      rd(rows[i].a, v);
      chk("register", v, rows[i].e);
    end
    $display("registers done");
    wr(ADDR_IPACE, 32'h100);
    wr(ADDR_MASK, 32'h1 << EV_RUN);
    cmd(CMD_PREPARE);
    rd(ADDR_CTRL, v);
    chk("armed", v, 32'h8);
    frames = 0;
    cmd(CMD_BEGIN);
    wr(ADDR_PICK, 32'h1);
    rd(ADDR_VALUE, v);
    chk("status", v, 32'h1);
    for (n = 0; n < 4000 && frames < 2; n++) @(negedge MCLK);
    if (frames < 2) failures++;
    chk("frame pace", img_gap, 32'h100);
    chk("line pace", ro_gap, 32'h10);
    await(W_IN, 1'b1);
    rcount = 0;
    v = frames;
    cmd(CMD_END);
    await(W_RB, 1'b0);
    chk("pixels", rcount, 32'h40);
    chk("no new frame", frames, v);
    chk("irq", IRQ, 1'b1);
    rd(ADDR_EVENT, v);
    chk("events", v, 32'h5);
    chk("irq clear", IRQ, 1'b0);
    $display("pacing and stop done");
    wr(ADDR_FRUN, 32'h3);
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_MODE, m);
      frames = 0;
      cmd(CMD_BEGIN);
      await(W_RB, 1'b1);
      await(W_RB, 1'b0);
      chk("run frames", frames, m ? 3 : 1);
    end
    rd(ADDR_CTRL, v);
    chk("ready", v, 32'h0);
    $display("counted runs done");
    rd(ADDR_EVENT, v);
    wr(ADDR_MODE, 32'h2);
    cmd(CMD_BEGIN);
    await(W_RO, 1'b1);
    cmd(CMD_CANCEL);
    @(negedge MCLK);
    chk("cancel", {RUN_BUSY, IMAGE_BUSY}, 2'b00);
    rd(ADDR_EVENT, v);
    chk("cancel events", v, 32'h4);
    $display("cancel done");
    wr(ADDR_MODE, 32'h6);
    frames = 0;
    cmd(CMD_BEGIN);
    await(W_IW, 1'b1);
    fire(PIN_IMAGE);
    await(W_IB, 1'b1);
    // With triggering on, every line needs its own row trigger while the line waits.
    repeat (8) begin
      await(W_IN, 1'b0);
      fire(PIN_ROW);
      await(W_RO, 1'b1);
      await(W_RO, 1'b0);
    end
    await(W_IW, 1'b1);
    cmd(CMD_END);
    await(W_RB, 1'b0);
    chk("trig frames", frames, 32'h1);
    $display("trigger stop done");
    wr(ADDR_MODE, 32'h40);
    icount = 0;
    rcount = 0;
    cmd(CMD_BEGIN);
    await(W_RB, 1'b1);
    await(W_RB, 1'b0);
    chk("scan expose", icount, 32'h20);
    chk("scan pixels", rcount, 32'h40);
    $display("line scan done");
    wr(ADDR_FGRP, 32'h2);
    for (int g = 0; g < 2; g++) begin
      wr(ADDR_MODE, g ? 32'h1A : 32'h0A);
      cmd(CMD_BEGIN);
      await(W_TW, 1'b1);
      frames = 0;
      fire(PIN_GBEGIN);
      await(W_IB, 1'b1);
      if (g) fire(PIN_GEND);
      await(W_TW, 1'b0);
      await(W_TW, 1'b1);
      chk("group frames", frames, g ? 1 : 2);
      chk("group xfer", GROUP_XFER, 1'b1);
      repeat (12) @(negedge MCLK);
      chk("group xfer end", GROUP_XFER, 1'b0);
      cmd(CMD_CANCEL);
    end
    wr(ADDR_MODE, 32'h22);
    cmd(CMD_BEGIN);
    await(W_TW, 1'b1);
    frames = 0;
    @(posedge MCLK);
    FIRE[PIN_GLEVEL] <= 1'b1;
    await(W_IB, 1'b1);
    @(posedge MCLK);
    FIRE[PIN_GLEVEL] <= 1'b0;
    await(W_TW, 1'b1);
    chk("level frames", frames, 32'h1);
    cmd(CMD_CANCEL);
    $display("groups done");
    give_verdict();
  end
endmodule : tb_acq_sequencer
`default_nettype wire
